// ---- common/abpm_pkg.sv ----
// Purpose: constants for the analog block port mux
// Assumes: 8-bit register contents, zero-extended to the bus width
// Notes:   software sees one register per aligned word
package abpm_pkg;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned REG_W  = 8;
    localparam int unsigned NCH    = 10;
    localparam int unsigned NIRQ   = 6;
    localparam int unsigned RES_W  = 12;

    // source selection lives in the upper two of ten parameter bits
    localparam logic [1:0] SRC_SW  = 2'h0;
    localparam logic [1:0] SRC_HW  = 2'h1;
    localparam logic [1:0] SRC_OFF = 2'h3;
    localparam int unsigned SRC_HI = 9;
    localparam int unsigned SRC_LO = 8;

    localparam logic [NCH-1:0] CH_ALL   = 10'h3FF;
    localparam logic [NCH-1:0] CH_SMALL = 10'h01F;

    // register byte addresses
    localparam logic [ADDR_W-1:0] A_CTRL    = 7'h00;
    localparam logic [ADDR_W-1:0] A_CLKDIV  = 7'h04;
    localparam logic [ADDR_W-1:0] A_STIME   = 7'h08;
    localparam logic [ADDR_W-1:0] A_CHAN    = 7'h0C;
    localparam logic [ADDR_W-1:0] A_GATE_LO = 7'h10;
    localparam logic [ADDR_W-1:0] A_GATE_HI = 7'h14;
    localparam logic [ADDR_W-1:0] A_CSTB_LO = 7'h18;
    localparam logic [ADDR_W-1:0] A_CSTB_HI = 7'h1C;
    localparam logic [ADDR_W-1:0] A_TSTB_LO = 7'h20;
    localparam logic [ADDR_W-1:0] A_TSTB_HI = 7'h24;
    localparam logic [ADDR_W-1:0] A_STATUS  = 7'h28;
    localparam logic [ADDR_W-1:0] A_RES_LO  = 7'h2C;
    localparam logic [ADDR_W-1:0] A_RES_HI  = 7'h30;
    localparam logic [ADDR_W-1:0] A_IRQ_MSK = 7'h34;
    localparam logic [ADDR_W-1:0] A_IRQ_STA = 7'h38;

    // control register fields; B_TINT is a field of A_TSTB_HI
    localparam int unsigned B_RST_PULSE = 0;
    localparam int unsigned B_START     = 1;
    localparam int unsigned B_PWRDN     = 2;
    localparam int unsigned B_REFSEL    = 3;
    localparam int unsigned B_MODE_LO   = 4;
    localparam int unsigned B_MODE_HI   = 7;
    localparam int unsigned B_TINT      = 2;

    // interrupt sources
    localparam int unsigned I_CAL_END  = 0;
    localparam int unsigned I_CONV_END = 1;
    localparam int unsigned I_VALID    = 2;
    localparam int unsigned I_CAL_BEG  = 3;
    localparam int unsigned I_CONV_BEG = 4;
    localparam int unsigned I_HW_START = 5;

    localparam logic [REG_W-1:0]  REG_RST  = 8'h00;
    localparam logic [NIRQ-1:0]   IRQ_NONE = 6'h00;
endpackage

// ---- design/abpm_top.sv ----
// Purpose: source mux between hardware pins and software registers
// Assumes: hw_* inputs are on clk_sys_i, analog block outputs are not
// Notes:   every output but bus_err_o (tied low) is a flop; control paths add one cycle, status paths two, digital monitors three
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module abpm_top
    import abpm_pkg::*;
#(
    parameter int unsigned BUS_WIDTH_PARAM      = 16,
    parameter logic        IRQ_ACTIVE_HIGH      = 1'b1,
    parameter logic        QUAD_DISABLE_PARAM   = 1'b1,
    parameter logic [9:0]  CONV_RESET_SRC_PARAM = 10'h000,
    parameter logic [9:0]  PWRDN_SRC_PARAM      = 10'h000,
    parameter logic [9:0]  REFSEL_SRC_PARAM     = 10'h000,
    parameter logic [9:0]  MODE_SRC_PARAM       = 10'h000,
    parameter logic [9:0]  CLKDIV_SRC_PARAM     = 10'h000,
    parameter logic [9:0]  STIME_SRC_PARAM      = 10'h000,
    parameter logic [9:0]  START_SRC_PARAM      = 10'h000,
    parameter logic [9:0]  CHANNEL_SRC_PARAM    = 10'h000,
    parameter logic [9:0]  TINT_SRC_PARAM       = 10'h000,
    parameter logic [99:0] VOLT_CFG_PARAM       = 100'h0,
    parameter logic [99:0] CURR_CFG_PARAM       = 100'h0,
    parameter logic [99:0] TEMP_CFG_PARAM       = 100'h0,
    parameter logic [99:0] GATE_CFG_PARAM       = 100'h0
) (
    input  wire logic                       clk_sys_i,
    input  wire logic                       sys_rst_i,
    // register port
    input  wire logic [ADDR_W-1:0]          reg_addr_i,
    input  wire logic [BUS_WIDTH_PARAM-1:0] reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic      [BUS_WIDTH_PARAM-1:0] reg_rdata_o,
    output logic                            bus_ready_o,
    output logic                            bus_err_o,
    output logic                            irq_o,
    // hardware control inputs
    input  wire logic                       hw_conv_reset_in_i,
    input  wire logic                       hw_powerdown_in_i,
    input  wire logic                       hw_ref_select_in_i,
    input  wire logic [3:0]                 hw_conv_mode_in_i,
    input  wire logic [7:0]                 hw_conv_clkdiv_in_i,
    input  wire logic [7:0]                 hw_sample_time_in_i,
    input  wire logic                       hw_conv_start_in_i,
    input  wire logic [4:0]                 hw_channel_sel_in_i,
    input  wire logic [NCH-1:0]             hw_gate_enable_in_i,
    input  wire logic [NCH-1:0]             hw_curr_strobe_in_i,
    input  wire logic [NCH-1:0]             hw_temp_strobe_in_i,
    input  wire logic                       hw_internal_temp_strobe_in_i,
    // from the analog block
    input  wire logic                       calibrating_out_i,
    input  wire logic                       converting_out_i,
    input  wire logic                       ab_valid_i,
    input  wire logic [RES_W-1:0]           conversion_result_out_i,
    input  wire logic [NCH-1:0]             ab_volt_dig_i,
    input  wire logic [NCH-1:0]             ab_curr_dig_i,
    input  wire logic [NCH-1:0]             ab_temp_dig_i,
    // to the analog block
    output logic                            ab_conv_reset_o,
    output logic                            ab_powerdown_o,
    output logic                            ab_ref_select_o,
    output logic      [3:0]                 ab_conv_mode_o,
    output logic      [7:0]                 ab_conv_clkdiv_o,
    output logic      [7:0]                 ab_sample_time_o,
    output logic                            ab_conv_start_o,
    output logic      [4:0]                 ab_channel_sel_o,
    output logic      [NCH-1:0]             ab_gate_drive_on_o,
    output logic      [NCH-1:0]             ab_curr_strobe_o,
    output logic      [NCH-1:0]             ab_temp_strobe_o,
    output logic                            ab_internal_temp_strobe_o,
    // status and digital pass-through
    output logic                            calibrating_out_o,
    output logic                            converting_out_o,
    output logic                            conversion_valid_out_o,
    output logic      [RES_W-1:0]           conversion_result_out_o,
    output logic      [NCH-1:0]             volt_mon_digital_out_o,
    output logic      [NCH-1:0]             curr_mon_digital_out_o,
    output logic      [NCH-1:0]             temp_mon_digital_out_o
);
    localparam int unsigned AB_W = RES_W + 3;
    localparam int unsigned DW   = BUS_WIDTH_PARAM;
    // upper quads vanish on the small dies
    localparam logic [NCH-1:0] AVAIL =
        QUAD_DISABLE_PARAM ? CH_ALL : CH_SMALL;

    function automatic logic is_hw(input logic [9:0] cfg);
        return cfg[SRC_HI:SRC_LO] == SRC_HW;
    endfunction
    function automatic logic is_off(input logic [9:0] cfg);
        return cfg[SRC_HI:SRC_LO] == SRC_OFF;
    endfunction

    typedef struct packed {
        logic [AB_W-1:0]    ab_s1;
        logic [AB_W-1:0]    ab_s2;
        logic [AB_W-1:0]    ab_prev;
        logic [3*NCH-1:0]   dig_s1;
        logic [3*NCH-1:0]   dig_s2;
        logic [3*NCH-1:0]   dig_out;
        logic               hw_start_prev;
        logic [REG_W-1:0]   ctrl;
        logic [REG_W-1:0]   clkdiv;
        logic [REG_W-1:0]   stime;
        logic [4:0]         chan;
        logic [NCH-1:0]     gate;
        logic [NCH-1:0]     cstb;
        logic [NCH-1:0]     tstb;
        logic               tint;
        logic               rst_pulse;
        logic               start_pulse;
        logic [NIRQ-1:0]    irq_mask;
        logic [NIRQ-1:0]    irq_stat;
        logic               irq;
        logic [DW-1:0]      rdata;
        logic               ready;
        logic               conv_reset;
        logic               pwrdn;
        logic               refsel;
        logic [3:0]         mode;
        logic [7:0]         clkdiv_o;
        logic [7:0]         stime_o;
        logic               start;
        logic [4:0]         chan_o;
        logic [NCH-1:0]     gate_o;
        logic [NCH-1:0]     cstb_o;
        logic [NCH-1:0]     tstb_o;
        logic               tint_o;
    } abpm_state_s;

    abpm_state_s st_ff;
    abpm_state_s nxt_st;

    logic             calib_now;
    logic             busy_now;
    logic             valid_now;
    logic             calib_was;
    logic             busy_was;
    logic             valid_was;
    logic [NIRQ-1:0]  irq_ev;
    logic [REG_W-1:0] rd_val;
    logic [9:0]       cfg;
    logic             src_hw;

    assign calib_now = st_ff.ab_s2[AB_W-1];
    assign busy_now  = st_ff.ab_s2[AB_W-2];
    assign valid_now = st_ff.ab_s2[AB_W-3];
    assign calib_was = st_ff.ab_prev[AB_W-1];
    assign busy_was  = st_ff.ab_prev[AB_W-2];
    assign valid_was = st_ff.ab_prev[AB_W-3];

    always_comb begin
        nxt_st = st_ff;
        rd_val = REG_RST;
        cfg    = 10'h000;
        src_hw = 1'b0;

        // analog block outputs arrive unsynchronised
        nxt_st.ab_s1   = {calibrating_out_i, converting_out_i, ab_valid_i, conversion_result_out_i};
        nxt_st.ab_s2   = st_ff.ab_s1;
        nxt_st.ab_prev = st_ff.ab_s2;
        nxt_st.dig_s1  = {ab_volt_dig_i, ab_curr_dig_i, ab_temp_dig_i};
        nxt_st.dig_s2  = st_ff.dig_s1;
        nxt_st.hw_start_prev = hw_conv_start_in_i;

        // digital versions only where the input is set digital
        for (int i = 0; i < NCH; i++) begin
            nxt_st.dig_out[2*NCH+i] = st_ff.dig_s2[2*NCH+i] & AVAIL[i] &
                is_hw(VOLT_CFG_PARAM[10*i +: 10]);
            nxt_st.dig_out[NCH+i] = st_ff.dig_s2[NCH+i] & AVAIL[i] &
                is_hw(CURR_CFG_PARAM[10*i +: 10]);
            nxt_st.dig_out[i] = st_ff.dig_s2[i] & AVAIL[i] &
                is_hw(TEMP_CFG_PARAM[10*i +: 10]);
        end

        // self-clearing pulses last one cycle
        nxt_st.rst_pulse   = 1'b0;
        nxt_st.start_pulse = 1'b0;
        nxt_st.ready       = 1'b1;

        irq_ev = IRQ_NONE;
        irq_ev[I_CAL_END]  = calib_was & ~calib_now;
        irq_ev[I_CONV_END] = busy_was & ~busy_now;
        irq_ev[I_VALID]    = valid_now & ~valid_was;
        irq_ev[I_CAL_BEG]  = calib_now & ~calib_was;
        irq_ev[I_CONV_BEG] = busy_now & ~busy_was;
        irq_ev[I_HW_START] = is_hw(START_SRC_PARAM) &
            hw_conv_start_in_i & ~st_ff.hw_start_prev;

        // writes; unmapped addresses are ignored
        if (reg_wr_i) begin
            if (reg_addr_i == A_CTRL) begin
                nxt_st.ctrl        = reg_wdata_i[REG_W-1:0];
                nxt_st.rst_pulse   = reg_wdata_i[B_RST_PULSE];
                nxt_st.start_pulse = reg_wdata_i[B_START];
            end else if (reg_addr_i == A_CLKDIV) begin
                nxt_st.clkdiv = reg_wdata_i[REG_W-1:0];
            end else if (reg_addr_i == A_STIME) begin
                nxt_st.stime = reg_wdata_i[REG_W-1:0];
            end else if (reg_addr_i == A_CHAN) begin
                nxt_st.chan = reg_wdata_i[4:0];
            end else if (reg_addr_i == A_GATE_LO) begin
                nxt_st.gate[7:0] = reg_wdata_i[7:0];
            end else if (reg_addr_i == A_GATE_HI) begin
                nxt_st.gate[9:8] = reg_wdata_i[1:0];
            end else if (reg_addr_i == A_CSTB_LO) begin
                nxt_st.cstb[7:0] = reg_wdata_i[7:0];
            end else if (reg_addr_i == A_CSTB_HI) begin
                nxt_st.cstb[9:8] = reg_wdata_i[1:0];
            end else if (reg_addr_i == A_TSTB_LO) begin
                nxt_st.tstb[7:0] = reg_wdata_i[7:0];
            end else if (reg_addr_i == A_TSTB_HI) begin
                nxt_st.tstb[9:8] = reg_wdata_i[1:0];
                nxt_st.tint      = reg_wdata_i[B_TINT];
            end else if (reg_addr_i == A_IRQ_MSK) begin
                nxt_st.irq_mask = reg_wdata_i[NIRQ-1:0];
            end
        end

        // reads; unmapped addresses return zero
        if (reg_addr_i == A_CTRL) begin
            rd_val = {st_ff.ctrl[REG_W-1:B_PWRDN], 2'h0};
        end else if (reg_addr_i == A_CLKDIV) begin
            rd_val = st_ff.clkdiv;
        end else if (reg_addr_i == A_STIME) begin
            rd_val = st_ff.stime;
        end else if (reg_addr_i == A_CHAN) begin
            rd_val = {3'h0, st_ff.chan};
        end else if (reg_addr_i == A_GATE_LO) begin
            rd_val = st_ff.gate[7:0];
        end else if (reg_addr_i == A_GATE_HI) begin
            rd_val = {6'h00, st_ff.gate[9:8]};
        end else if (reg_addr_i == A_CSTB_LO) begin
            rd_val = st_ff.cstb[7:0];
        end else if (reg_addr_i == A_CSTB_HI) begin
            rd_val = {6'h00, st_ff.cstb[9:8]};
        end else if (reg_addr_i == A_TSTB_LO) begin
            rd_val = st_ff.tstb[7:0];
        end else if (reg_addr_i == A_TSTB_HI) begin
            rd_val = {5'h00, st_ff.tint, st_ff.tstb[9:8]};
        end else if (reg_addr_i == A_STATUS) begin
            rd_val = {5'h00, calib_now, busy_now, valid_now};
        end else if (reg_addr_i == A_RES_LO) begin
            rd_val = st_ff.ab_s2[7:0];
        end else if (reg_addr_i == A_RES_HI) begin
            rd_val = {4'h0, st_ff.ab_s2[RES_W-1:8]};
        end else if (reg_addr_i == A_IRQ_MSK) begin
            rd_val = {2'h0, st_ff.irq_mask};
        end else if (reg_addr_i == A_IRQ_STA) begin
            rd_val = {2'h0, st_ff.irq_stat};
        end
        if (reg_rd_i) begin
            nxt_st.rdata = DW'(rd_val);
        end

        // a read clears the status, a same-cycle event still sets it
        if (reg_rd_i && reg_addr_i == A_IRQ_STA) begin
            nxt_st.irq_stat = irq_ev;
        end else begin
            nxt_st.irq_stat = st_ff.irq_stat | irq_ev;
        end
        // polarity is a build choice, not a register
        nxt_st.irq = ~(|(nxt_st.irq_stat & st_ff.irq_mask)) ^
            IRQ_ACTIVE_HIGH;

        // scalar controls: hardware, off, or software
        nxt_st.conv_reset = is_hw(CONV_RESET_SRC_PARAM) ? hw_conv_reset_in_i :
            ~is_off(CONV_RESET_SRC_PARAM) & st_ff.rst_pulse;
        nxt_st.pwrdn = is_hw(PWRDN_SRC_PARAM) ? hw_powerdown_in_i :
            ~is_off(PWRDN_SRC_PARAM) & st_ff.ctrl[B_PWRDN];
        nxt_st.refsel = is_hw(REFSEL_SRC_PARAM) ? hw_ref_select_in_i :
            ~is_off(REFSEL_SRC_PARAM) & st_ff.ctrl[B_REFSEL];
        nxt_st.mode = is_hw(MODE_SRC_PARAM) ? hw_conv_mode_in_i :
            (is_off(MODE_SRC_PARAM) ? 4'h0 :
             st_ff.ctrl[B_MODE_HI:B_MODE_LO]);
        nxt_st.clkdiv_o = is_hw(CLKDIV_SRC_PARAM) ? hw_conv_clkdiv_in_i :
            (is_off(CLKDIV_SRC_PARAM) ? 8'h00 : st_ff.clkdiv);
        nxt_st.stime_o = is_hw(STIME_SRC_PARAM) ? hw_sample_time_in_i :
            (is_off(STIME_SRC_PARAM) ? 8'h00 : st_ff.stime);
        nxt_st.start = is_hw(START_SRC_PARAM) ? hw_conv_start_in_i :
            ~is_off(START_SRC_PARAM) & st_ff.start_pulse;
        nxt_st.chan_o = is_hw(CHANNEL_SRC_PARAM) ? hw_channel_sel_in_i :
            (is_off(CHANNEL_SRC_PARAM) ? 5'h00 : st_ff.chan);

        // per-channel gates and strobes; disabled quads stay low
        src_hw = is_hw(CHANNEL_SRC_PARAM);
        for (int i = 0; i < NCH; i++) begin
            cfg = GATE_CFG_PARAM[10*i +: 10];
            nxt_st.gate_o[i] = AVAIL[i] & ~is_off(cfg) &
                (is_hw(cfg) ? hw_gate_enable_in_i[i] : st_ff.gate[i]);
            cfg = CURR_CFG_PARAM[10*i +: 10];
            nxt_st.cstb_o[i] = AVAIL[i] & ~is_off(cfg) &
                (src_hw ? hw_curr_strobe_in_i[i] : st_ff.cstb[i]);
            cfg = TEMP_CFG_PARAM[10*i +: 10];
            nxt_st.tstb_o[i] = AVAIL[i] & ~is_off(cfg) &
                (src_hw ? hw_temp_strobe_in_i[i] : st_ff.tstb[i]);
        end
        nxt_st.tint_o = is_hw(TINT_SRC_PARAM) ? hw_internal_temp_strobe_in_i :
            ~is_off(TINT_SRC_PARAM) & st_ff.tint;
    end

    // house reset is synchronous; every flop takes a constant
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_ff       <= '0;
            st_ff.ready <= 1'b1;
            st_ff.irq   <= ~IRQ_ACTIVE_HIGH;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata_o               = st_ff.rdata;
    assign bus_ready_o               = st_ff.ready;
    assign bus_err_o                 = st_ff.tint & 1'b0;
    assign irq_o                     = st_ff.irq;
    assign ab_conv_reset_o           = st_ff.conv_reset;
    assign ab_powerdown_o            = st_ff.pwrdn;
    assign ab_ref_select_o           = st_ff.refsel;
    assign ab_conv_mode_o            = st_ff.mode;
    assign ab_conv_clkdiv_o          = st_ff.clkdiv_o;
    assign ab_sample_time_o          = st_ff.stime_o;
    assign ab_conv_start_o           = st_ff.start;
    assign ab_channel_sel_o          = st_ff.chan_o;
    assign ab_gate_drive_on_o        = st_ff.gate_o;
    assign ab_curr_strobe_o          = st_ff.cstb_o;
    assign ab_temp_strobe_o          = st_ff.tstb_o;
    assign ab_internal_temp_strobe_o = st_ff.tint_o;
    assign calibrating_out_o         = calib_now;
    assign converting_out_o          = busy_now;
    assign conversion_valid_out_o    = valid_now;
    assign conversion_result_out_o   = st_ff.ab_s2[RES_W-1:0];
    assign volt_mon_digital_out_o    = st_ff.dig_out[3*NCH-1:2*NCH];
    assign curr_mon_digital_out_o    = st_ff.dig_out[2*NCH-1:NCH];
    assign temp_mon_digital_out_o    = st_ff.dig_out[NCH-1:0];
endmodule
`default_nettype wire

// ---- dv/abpm_ab_model.sv ----
// Purpose: behavioural analog block for the port mux bench
// Assumes: reset and start reach it as one-cycle pulses
// Notes:   result reads inverted while busy, never stale
`timescale 1ns/1ns
`default_nettype none
module abpm_ab_model (
    input  wire logic        clk_i, conv_reset_i, conv_start_i,
    input  wire logic [4:0]  channel_i,
    output logic             calibrate_o = 1'b0, busy_o = 1'b0, valid_o = 1'b0,
    output logic      [11:0] result_o = 12'h000
);
    int cnt = 0;
    always @(posedge clk_i) begin
        if (conv_reset_i) begin
            calibrate_o <= 1'b1;
            cnt <= 6;
        end else if (conv_start_i) begin
            {busy_o, valid_o, result_o} <= {2'b10, ~result_o};
            cnt <= 5;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (busy_o) begin
            {busy_o, valid_o, result_o} <= {2'b01, 7'h2B, channel_i};
        end else begin
            calibrate_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- dv/abpm_top_asserts.sv ----
// Purpose: port checker for abpm_top
// Assumes: channel source and interrupt polarity arrive through bind
// Notes:   status paths held to the two-cycle synchroniser delay
`timescale 1ns/1ns
`default_nettype none
module abpm_top_asserts
    import abpm_pkg::*;
#(
    parameter logic       IRQ_ACTIVE_HIGH   = 1'b1,
    parameter logic [9:0] CHANNEL_SRC_PARAM = 10'h000
) (
    input wire logic clk_sys_i, sys_rst_i, bus_ready_o, bus_err_o, irq_o,
    input wire logic calibrating_out_i, calibrating_out_o, converting_out_i,
    input wire logic converting_out_o, ab_valid_i, conversion_valid_out_o,
    input wire logic [4:0]  hw_channel_sel_in_i, ab_channel_sel_o,
    input wire logic [11:0] conversion_result_out_i, conversion_result_out_o
);
    // delayed checks wait until the sync chain has reloaded
    logic [1:0] rst_hist_ff;
    always_ff @(posedge clk_sys_i) rst_hist_ff <= {rst_hist_ff[0], sys_rst_i};
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    a_ready_high: assert property (bus_ready_o)
        else $error("bus ready low");
    a_err_low: assert property (!bus_err_o)
        else $error("bus error high");
    a_irq_idle: assert property (
        $fell(sys_rst_i) |-> irq_o == !IRQ_ACTIVE_HIGH)
        else $error("interrupt active out of reset");
    a_chan_follow: assert property (
        CHANNEL_SRC_PARAM[9:8] == SRC_HW && !rst_hist_ff[0]
        |-> ab_channel_sel_o == $past(hw_channel_sel_in_i))
        else $error("channel not following hardware input");
    a_cal_delay: assert property (rst_hist_ff == 2'h0 |->
        calibrating_out_o == $past(calibrating_out_i, 2))
        else $error("calibrate status wrong");
    a_busy_delay: assert property (rst_hist_ff == 2'h0 |->
        converting_out_o == $past(converting_out_i, 2))
        else $error("busy status wrong");
    a_valid_delay: assert property (rst_hist_ff == 2'h0 |->
        conversion_valid_out_o == $past(ab_valid_i, 2))
        else $error("valid status wrong");
    a_result_hold: assert property (conversion_valid_out_o |->
        conversion_result_out_o == $past(conversion_result_out_i, 2))
        else $error("result wrong while valid");
endmodule
bind abpm_top abpm_top_asserts #(
    .IRQ_ACTIVE_HIGH(IRQ_ACTIVE_HIGH), .CHANNEL_SRC_PARAM(CHANNEL_SRC_PARAM)
) i_asserts (.*);
`default_nettype wire

// ---- dv/abpm_top_bench.sv ----
// Purpose: self-checking bench for abpm_top
// Assumes: one build mixing hardware, software and disabled sources
// Notes:   analog stand-in answers the reset and start pulses
`timescale 1ns/1ns
`default_nettype none
module abpm_top_bench
    import abpm_pkg::*;
;
    localparam logic        IRQ_POL = 1'b0;
    localparam logic [11:0] RES     = {7'h2B, 5'h13};
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
$display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
    int   err_total = 0, n_tests = 0, i;
    logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic hw_powerdown_in_i = 1'b0, hw_conv_start_in_i = 1'b0;
    logic hw_conv_reset_in_i = 1'b0, hw_ref_select_in_i = 1'b0;
    logic hw_internal_temp_strobe_in_i = 1'b0;
    logic bus_ready_o, bus_err_o, irq_o, ab_conv_reset_o, ab_powerdown_o;
    logic ab_ref_select_o, ab_conv_start_o, ab_internal_temp_strobe_o;
    logic calibrating_out_o, converting_out_o, conversion_valid_out_o;
    logic calibrating_out_i, converting_out_i, ab_valid_i;
    logic [3:0]  hw_conv_mode_in_i = 4'h0, ab_conv_mode_o;
    logic [4:0]  hw_channel_sel_in_i = 5'h00, ab_channel_sel_o;
    logic [6:0]  reg_addr_i = 7'h00;
    logic [7:0]  hw_conv_clkdiv_in_i = 8'h00, ab_conv_clkdiv_o;
    logic [7:0]  hw_sample_time_in_i = 8'h00, ab_sample_time_o;
    logic [9:0]  hw_gate_enable_in_i = 10'h000, hw_curr_strobe_in_i = 10'h000;
    logic [9:0]  hw_temp_strobe_in_i = 10'h000, ab_volt_dig_i = 10'h000;
    logic [9:0]  ab_curr_dig_i = 10'h000, ab_temp_dig_i = 10'h000;
    logic [9:0]  ab_gate_drive_on_o, ab_curr_strobe_o, ab_temp_strobe_o;
    logic [9:0]  volt_mon_digital_out_o, curr_mon_digital_out_o;
    logic [9:0]  temp_mon_digital_out_o;
    logic [11:0] conversion_result_out_i, conversion_result_out_o;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
    abpm_top #(
        .IRQ_ACTIVE_HIGH(IRQ_POL), .PWRDN_SRC_PARAM(10'h100),
        .MODE_SRC_PARAM(10'h1C5), .CLKDIV_SRC_PARAM(10'h100),
        .START_SRC_PARAM(10'h100), .CHANNEL_SRC_PARAM(10'h100),
        .TINT_SRC_PARAM(10'h300), .VOLT_CFG_PARAM(100'h100),
        .CURR_CFG_PARAM({10'h300, 90'h0}),
        .GATE_CFG_PARAM({80'h0, 10'h300, 10'h100})
    ) i_dut (.*);
    abpm_ab_model i_ab (
        .clk_i(clk_sys_i), .conv_reset_i(ab_conv_reset_o),
        .conv_start_i(ab_conv_start_o), .channel_i(ab_channel_sel_o),
        .calibrate_o(calibrating_out_i), .busy_o(converting_out_i),
        .valid_o(ab_valid_i), .result_o(conversion_result_out_i)
    );
    task automatic bus(input logic w, input logic [6:0] a, logic [15:0] d);
        @(posedge clk_sys_i);
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, !w, a, d};
        @(posedge clk_sys_i);
        {reg_wr_i, reg_rd_i} <= 2'b00;
        #1 if (!w) `CHK(reg_rdata_o, d)
    endtask
    // start pin pulse, then result, interrupt and its clear-on-read
    task automatic conv(input logic [15:0] sta, input logic irq_on);
        @(posedge clk_sys_i);
        hw_conv_start_in_i <= 1'b1;
        @(posedge clk_sys_i);
        hw_conv_start_in_i <= 1'b0;
        for (i = 0; i < 40 && !converting_out_o; i++) @(posedge clk_sys_i);
        #1 `CHK(converting_out_o, 1'b1)
        for (i = 0; i < 40 && !conversion_valid_out_o; i++)
            @(posedge clk_sys_i);
        #1 `CHK({converting_out_o, conversion_result_out_o}, {1'b0, RES})
        bus(1'b0, A_RES_LO, {8'h00, RES[7:0]});
        #8 `CHK(irq_o, irq_on)
        bus(1'b0, A_IRQ_STA, sta);
        #8 `CHK(irq_o, ~IRQ_POL)
    endtask
    task automatic t_mux();
        bus(1'b1, A_CTRL, 16'h00FC);
        bus(1'b1, A_STIME, 16'h005C);
        bus(1'b1, A_GATE_LO, 16'h0007);
        bus(1'b1, A_GATE_HI, 16'h0003);
        #12 `CHK({ab_powerdown_o, ab_ref_select_o}, 2'b11)
        `CHK(ab_conv_mode_o, 4'h9)
        `CHK({ab_conv_clkdiv_o, ab_sample_time_o}, 16'hA75C)
        `CHK(ab_gate_drive_on_o, 10'h305)
        `CHK(ab_curr_strobe_o, 10'h0A5)
        `CHK({ab_temp_strobe_o, ab_internal_temp_strobe_o}, 11'h2B4)
        `CHK({volt_mon_digital_out_o, curr_mon_digital_out_o,
            temp_mon_digital_out_o}, 30'h00100000)
        bus(1'b0, A_STIME, 16'h005C);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial forever #2 clk_sys_i = ~clk_sys_i;
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        {hw_conv_mode_in_i, hw_conv_clkdiv_in_i} <= 12'h9A7;
        {hw_channel_sel_in_i, hw_curr_strobe_in_i} <= {5'h13, 10'h2A5};
        hw_temp_strobe_in_i <= 10'h15A;
        // hardware-sourced pins carry live levels, off ones must not leak
        hw_powerdown_in_i <= 1'b1;
        hw_gate_enable_in_i <= 10'h0FB;
        hw_internal_temp_strobe_in_i <= 1'b1;
        {ab_volt_dig_i, ab_curr_dig_i, ab_temp_dig_i} <= {30{1'b1}};
        bus(1'b0, 7'h7C, 16'h0000);
        `CHK({bus_ready_o, bus_err_o}, 2'b10)
        t_mux();
        bus(1'b1, A_IRQ_MSK, 16'h003F);
        bus(1'b1, A_CTRL, 16'h0001);
        for (i = 0; i < 40 && !calibrating_out_o; i++) @(posedge clk_sys_i);
        #1 `CHK(calibrating_out_o, 1'b1)
        for (i = 0; i < 40 && calibrating_out_o; i++) @(posedge clk_sys_i);
        conv(16'h003F, IRQ_POL);
        bus(1'b1, A_IRQ_MSK, 16'h0000);
        conv(16'h0036, ~IRQ_POL);
        end_of_test();
    end
endmodule
`default_nettype wire
